// >>> design/comparator_pair_control.sv
// control logic for a pair of analog comparators: registers, modes,
// start-up timing, filtering, edge detection, events and clock requests
// assumes raw comparator outputs asynchronous to i_mclk and event inputs
// already synchronous to i_mclk
`timescale 1ns/100ps
`default_nettype none

module comparator_pair_control
  import comparator_pair_pkg::*;
#(
  parameter int STARTUP = STARTUP_CYCLES
) (
  input  wire logic              i_mclk,
  input  wire logic              i_rst,
  input  wire logic [ADDR_W-1:0] i_addr,
  input  wire logic [31:0]       i_wdata,
  input  wire logic              i_wr,
  input  wire logic              i_rd,
  output logic      [31:0]       o_rdata,
  input  wire logic [NCOMP-1:0]  i_cmp_raw,
  input  wire logic [NCOMP-1:0]  i_event_in,
  input  wire logic              i_sleep,
  output logic      [NCOMP-1:0]  o_analog_enable,
  output logic      [NCOMP-1:0]  o_event_out,
  output logic      [NCOMP-1:0]  o_irq_cond,
  output logic                   o_trigger_busy,
  output logic                   o_clk_request
);

  logic             soft_reset;
  logic             global_en;
  logic             wake_en;
  logic [7:0]       event_ctrl;
  logic [31:0]      comp_ctrl [NCOMP];
  logic [NCOMP-1:0] raw_meta;
  logic [NCOMP-1:0] raw_s;
  logic [NCOMP-1:0] result;
  logic [NCOMP-1:0] ready;
  logic [NCOMP-1:0] busy;
  logic [NCOMP-1:0] en_eff;
  logic [NCOMP-1:0] single_en;
  logic [NCOMP-1:0] start_req;
  logic [NCOMP-1:0] start_wr;
  logic [NCOMP-1:0] changed;
  logic             trig_rd;
  logic             trig_pending;
  logic             next_trig_pending;

  assign start_wr = (i_wr && i_addr == OFS_START_REGISTER) ?
                    i_wdata[NCOMP-1:0] : '0;
  assign trig_rd  = i_rd && i_addr == OFS_TRIGGER_STATUS;

  // raw outputs are asynchronous; the first stage feeds only the second
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      raw_meta <= '0;
      raw_s    <= '0;
    end else begin
      raw_meta <= i_cmp_raw;
      raw_s    <= raw_meta;
    end
  end

  // soft reset acts on the edge of its own write, so an access right
  // behind it already meets the reset values and is never lost
  assign soft_reset = i_wr && i_addr == OFS_GLOBAL_CONTROL &&
                      i_wdata[GC_SOFT_RESET];

  // a soft reset write ignores the other bits it carries
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      global_en <= RST_GLOBAL[GC_ENABLE];
      wake_en   <= RST_GLOBAL[GC_WAKE];
    end else if (soft_reset) begin
      global_en <= RST_GLOBAL[GC_ENABLE];
      wake_en   <= RST_GLOBAL[GC_WAKE];
    end else if (i_wr && i_addr == OFS_GLOBAL_CONTROL &&
                 !i_wdata[GC_SOFT_RESET]) begin
      global_en <= i_wdata[GC_ENABLE];
      wake_en   <= i_wdata[GC_WAKE];
    end
  end

  // routing is frozen while enabled so a live event is never misrouted
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      event_ctrl <= RST_EVENT_CONTROL;
    end else if (soft_reset) begin
      event_ctrl <= RST_EVENT_CONTROL;
    end else if (i_wr && i_addr == OFS_EVENT_CONTROL && !global_en) begin
      event_ctrl <= i_wdata[7:0];
    end
  end

  for (genvar c = 0; c < NCOMP; c++) begin : g_comp
    comp_state_t      state;
    logic [CNT_W-1:0] cnt;
    logic [CNT_W-1:0] need;
    logic [3:0]       hist;
    logic [4:0]       win;
    logic [2:0]       ones;
    logic             maj;
    logic             done;
    logic             cmp_evt;
    logic             cond;
    logic [1:0]       filter_length;
    logic [1:0]       isel;
    logic             ev_in_en;
    logic [ADDR_W-1:0] my_ofs;

    assign my_ofs   = (c == 0) ? OFS_COMP_CONTROL0 : OFS_COMP_CONTROL1;
    assign filter_length     = comp_ctrl[c][CC_FILTER_LENGTH_LSB +: 2];
    assign isel     = comp_ctrl[c][CC_IRQSEL_LSB +: 2];
    assign ev_in_en = event_ctrl[EC_EVIN_LSB + c];
    // global disable gates the comparator but leaves its own bit stored
    assign en_eff[c]    = global_en && comp_ctrl[c][CC_ENABLE];
    assign single_en[c] = en_eff[c] && comp_ctrl[c][CC_SINGLE];
    // a busy comparator takes no further start
    assign start_req[c] = single_en[c] && state == ST_OFF &&
                          (start_wr[c] || trig_rd ||
                           (i_event_in[c] && ev_in_en));
    assign busy[c] = single_en[c] && state != ST_OFF;

    // only the enable bit stays writable while the comparator's enable bit is set
    always_ff @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) begin
        comp_ctrl[c] <= RST_COMP_CONTROL;
      end else if (soft_reset) begin
        comp_ctrl[c] <= RST_COMP_CONTROL;
      end else if (i_wr && i_addr == my_ofs) begin
        if (comp_ctrl[c][CC_ENABLE]) begin
          comp_ctrl[c][CC_ENABLE] <= i_wdata[CC_ENABLE];
        end else begin
          comp_ctrl[c] <= i_wdata & CC_WRITE_MASK;
        end
      end
    end

    // samples before the first result; reserved codes fall back to one
    always_comb begin
      case (filter_length)
        FILTER_LENGTH_MAJ3: need = CNT_W'(3);
        FILTER_LENGTH_MAJ5: need = CNT_W'(5);
        default:   need = CNT_W'(1);
      endcase
    end

    // majority over the newest N samples, the live sample included
    assign win  = {hist, raw_s[c]};
    assign ones = 3'(win[0]) + 3'(win[1]) + 3'(win[2]) +
                  3'(win[3]) + 3'(win[4]);
    always_comb begin
      case (filter_length)
        FILTER_LENGTH_MAJ3: maj = (3'(win[0]) + 3'(win[1]) + 3'(win[2])) >= 3'h2;
        FILTER_LENGTH_MAJ5: maj = ones >= 3'h3;
        default:   maj = win[0];
      endcase
    end

    assign done    = state == ST_SAMPLE && cnt == need - CNT_W'(1);
    assign cmp_evt = done || state == ST_RUN;
    // a change of the result, whatever interrupt condition is selected
    assign changed[c] = cmp_evt && maj != result[c];

    // start-up counts first, then the filter fills before the first result
    always_ff @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) begin
        state <= ST_OFF;
        cnt   <= '0;
      end else if (soft_reset || !en_eff[c]) begin
        state <= ST_OFF;
        cnt   <= '0;
      end else begin
        case (state)
          ST_OFF: begin
            if (!comp_ctrl[c][CC_SINGLE] || start_req[c]) begin
              state <= ST_STARTUP;
            end
            cnt <= '0;
          end
          ST_STARTUP: begin
            if (cnt == CNT_W'(STARTUP - 1)) begin
              state <= ST_SAMPLE;
              cnt   <= '0;
            end else begin
              cnt <= cnt + CNT_W'(1);
            end
          end
          ST_SAMPLE: begin
            if (done) begin
              // in continuous mode the delay applies only before the first comparison
              state <= comp_ctrl[c][CC_SINGLE] ? ST_OFF : ST_RUN;
              cnt   <= '0;
            end else begin
              cnt <= cnt + CNT_W'(1);
            end
          end
          ST_RUN: begin
            state <= ST_RUN;
          end
          default: begin
            state <= ST_OFF;
          end
        endcase
      end
    end

    // history restarts with every start-up so stale samples never vote
    always_ff @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) begin
        hist <= '0;
      end else if (state == ST_SAMPLE || state == ST_RUN) begin
        hist <= win[3:0];
      end else begin
        hist <= '0;
      end
    end

    // previous result is kept across single-shot measurements
    always_comb begin
      case (isel)
        IRQ_TOGGLE: cond = maj != result[c];
        IRQ_RISE:   cond = maj && !result[c];
        IRQ_FALL:   cond = !maj && result[c];
        default:    cond = 1'b1;
      endcase
    end

    always_ff @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) begin
        result[c]     <= 1'b0;
        o_irq_cond[c] <= 1'b0;
      end else if (soft_reset) begin
        result[c]     <= 1'b0;
        o_irq_cond[c] <= 1'b0;
      end else begin
        o_irq_cond[c] <= cmp_evt && cond;
        if (cmp_evt) begin
          result[c] <= maj;
        end
      end
    end

    // the event line follows the result even with every interrupt unused
    always_ff @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) begin
        o_event_out[c] <= 1'b0;
      end else if (soft_reset) begin
        o_event_out[c] <= 1'b0;
      end else begin
        o_event_out[c] <= event_ctrl[EC_EVOUT_LSB + c] &&
                          (cmp_evt ? maj : result[c]);
      end
    end

    // completion wins over a clear in the same cycle
    always_ff @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) begin
        ready[c] <= 1'b0;
      end else if (soft_reset) begin
        ready[c] <= 1'b0;
      end else if (done) begin
        ready[c] <= 1'b1;
      end else if (start_req[c] || !en_eff[c]) begin
        ready[c] <= 1'b0;
      end
    end

    always_ff @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) begin
        o_analog_enable[c] <= 1'b0;
      end else if (soft_reset) begin
        o_analog_enable[c] <= 1'b0;
      end else begin
        // single-shot powers the core only for one comparison
        o_analog_enable[c] <= en_eff[c] && !(done &&
                              comp_ctrl[c][CC_SINGLE]) &&
                              (!comp_ctrl[c][CC_SINGLE] ||
                               state != ST_OFF || start_req[c]);
      end
    end
  end

  // read completes at once; o_trigger_busy stands in for the bus stall
  // limitation: software polls o_trigger_busy before trusting ready bits
  always_comb begin
    next_trig_pending = trig_pending;
    if (trig_rd && |single_en) begin
      next_trig_pending = 1'b1;
    end
    if (next_trig_pending && ((ready & en_eff) == en_eff) &&
        !(|(busy | start_req))) begin
      next_trig_pending = 1'b0;
    end
  end

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      trig_pending   <= 1'b0;
      o_trigger_busy <= 1'b0;
    end else if (soft_reset) begin
      trig_pending   <= 1'b0;
      o_trigger_busy <= 1'b0;
    end else begin
      trig_pending   <= next_trig_pending;
      o_trigger_busy <= next_trig_pending;
    end
  end

  // clock held while a sleeping single-shot measurement runs or a result changes
  // keyed to result changes, so end-of-compare pins the clock on only through ready with wake_en set
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      o_clk_request <= 1'b0;
    end else if (soft_reset) begin
      o_clk_request <= 1'b0;
    end else begin
      o_clk_request <= i_sleep && (|busy || |start_req || |changed ||
                       (wake_en && |ready));
    end
  end

  // read data stand for one cycle only, zero otherwise
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      o_rdata <= '0;
    end else if (i_rd) begin
      case (i_addr)
        OFS_GLOBAL_CONTROL: o_rdata <= {29'h0, wake_en, global_en, 1'b0};
        OFS_EVENT_CONTROL:  o_rdata <= {24'h0, event_ctrl};
        OFS_STATE_STATUS:   o_rdata <= {30'h0, result};
        OFS_READY_STATUS:   o_rdata <= {30'h0, ready};
        OFS_TRIGGER_STATUS: o_rdata <= {30'h0, ready};
        OFS_COMP_CONTROL0:  o_rdata <= comp_ctrl[0];
        OFS_COMP_CONTROL1:  o_rdata <= comp_ctrl[1];
        default:            o_rdata <= '0;
      endcase
    end else begin
      o_rdata <= '0;
    end
  end

endmodule

`default_nettype wire

// >>> design/comparator_pair_pkg.sv
// constants, register map and state type for the comparator pair control
// assumes a 100 MHz bus clock and two analog comparator cores
package comparator_pair_pkg;

  localparam int NCOMP    = 2;
  localparam int ADDR_W   = 8;
  localparam int CLK_MHZ  = 100;

  // register byte offsets
  localparam logic [7:0] OFS_GLOBAL_CONTROL = 8'h00;
  localparam logic [7:0] OFS_START_REGISTER = 8'h04;
  localparam logic [7:0] OFS_EVENT_CONTROL  = 8'h08;
  localparam logic [7:0] OFS_STATE_STATUS   = 8'h0c;
  localparam logic [7:0] OFS_READY_STATUS   = 8'h10;
  localparam logic [7:0] OFS_TRIGGER_STATUS = 8'h14;
  localparam logic [7:0] OFS_COMP_CONTROL0  = 8'h18;
  localparam logic [7:0] OFS_COMP_CONTROL1  = 8'h1c;

  // global_control fields
  localparam int GC_SOFT_RESET = 0;
  localparam int GC_ENABLE     = 1;
  localparam int GC_WAKE       = 2;

  // event_control fields: output enables, then event input enables
  localparam int EC_EVOUT_LSB  = 0;
  localparam int EC_EVIN_LSB   = 4;

  // comparator_control fields
  localparam int CC_ENABLE     = 0;
  localparam int CC_SINGLE     = 1;
  localparam int CC_IRQSEL_LSB = 2;
  localparam int CC_HYST       = 4;
  localparam int CC_SPEED_LSB  = 5;
  localparam int CC_FILTER_LENGTH_LSB   = 8;
  localparam int CC_STDBY      = 12;
  localparam int CC_PLUS_LSB   = 16;
  localparam int CC_MINUS_LSB  = 20;
  localparam logic [31:0] CC_WRITE_MASK = 32'h0077_137f;

  // reset values
  localparam logic [31:0] RST_COMP_CONTROL  = 32'h0000_0000;
  localparam logic [7:0]  RST_EVENT_CONTROL = 8'h00;
  localparam logic [2:0]  RST_GLOBAL        = 3'h0;

  // interrupt condition encodings
  localparam logic [1:0] IRQ_TOGGLE  = 2'h0;
  localparam logic [1:0] IRQ_RISE    = 2'h1;
  localparam logic [1:0] IRQ_FALL    = 2'h2;
  localparam logic [1:0] IRQ_EOC     = 2'h3;

  // filter length encodings
  localparam logic [1:0] FILTER_LENGTH_NONE   = 2'h0;
  localparam logic [1:0] FILTER_LENGTH_MAJ3   = 2'h1;
  localparam logic [1:0] FILTER_LENGTH_MAJ5   = 2'h2;

  // start-up delay of an analog core
  localparam int STARTUP_TIME_NS = 2000;
  localparam int STARTUP_CYCLES  = (STARTUP_TIME_NS * CLK_MHZ + 999) / 1000;
  localparam int CNT_W           = 12;

  typedef enum logic [1:0] {
    ST_OFF,
    ST_STARTUP,
    ST_SAMPLE,
    ST_RUN
  } comp_state_t;

endpackage

// >>> test/comparator_pair_assertions.sv
// port-level checks of the comparator pair control
// assumes the bind below and the same STARTUP as the design instance
`timescale 1ns/100ps
`default_nettype none

module comparator_pair_checker
  import comparator_pair_pkg::*;
#(
  parameter int STARTUP = STARTUP_CYCLES
) (
  input wire logic              i_mclk,
  input wire logic              i_rst,
  input wire logic [ADDR_W-1:0] i_addr,
  input wire logic [31:0]       i_wdata,
  input wire logic              i_wr,
  input wire logic              i_rd,
  input wire logic [31:0]       o_rdata,
  input wire logic [NCOMP-1:0]  i_cmp_raw,
  input wire logic [NCOMP-1:0]  i_event_in,
  input wire logic              i_sleep,
  input wire logic [NCOMP-1:0]  o_analog_enable,
  input wire logic [NCOMP-1:0]  o_event_out,
  input wire logic [NCOMP-1:0]  o_irq_cond,
  input wire logic              o_trigger_busy,
  input wire logic              o_clk_request
);
  logic       g_en;
  logic [1:0] s_en;
  logic [1:0] s_single;
  logic       trig_rd;
  logic       any_single;

  assign trig_rd    = i_rd && (i_addr == OFS_TRIGGER_STATUS);
  assign any_single = g_en && |(s_en & s_single);

  // shadow enables; single is locked while its comparator is on
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      g_en     <= 1'b0;
      s_en     <= 2'h0;
      s_single <= 2'h0;
    end else if (i_wr) begin
      for (int k = 0; k < 2; k++) begin
        if (i_addr == OFS_COMP_CONTROL0 + 8'(4 * k)) begin
          s_en[k] <= i_wdata[CC_ENABLE];
          if (!s_en[k]) begin
            s_single[k] <= i_wdata[CC_SINGLE];
          end
        end
      end
      if (i_addr == OFS_GLOBAL_CONTROL && i_wdata[GC_SOFT_RESET]) begin
        g_en     <= 1'b0;
        s_en     <= 2'h0;
        s_single <= 2'h0;
      end else if (i_addr == OFS_GLOBAL_CONTROL) begin
        g_en <= i_wdata[GC_ENABLE];
      end
    end
  end

  default clocking cb @(posedge i_mclk);
  endclocking
  default disable iff (i_rst);

  a_startup_quiet: assert property (
    $rose(o_analog_enable[0]) |-> (!o_irq_cond[0]) [*4])
    else $error("result raised during start-up");
  a_global_stop: assert property (
    (!g_en) [*3] |-> o_analog_enable == 2'h0)
    else $error("core powered while unit disabled");
  a_single_once: assert property (
    $rose(o_analog_enable[0]) && s_single[0]
      |-> o_analog_enable[0] [*5] ##[1:3] !o_analog_enable[0])
    else $error("single compare did not end once");
  a_clk_asleep: assert property (
    o_clk_request |-> $past(i_sleep))
    else $error("clock request while awake");
  a_sleep_event_clk: assert property (
    i_sleep && $rose(o_analog_enable[0]) |-> ##[0:2] o_clk_request)
    else $error("no clock request for sleep compare");
  a_busy_cause: assert property (
    $rose(o_trigger_busy) |-> $past(trig_rd))
    else $error("busy without trigger read");
  a_trig_starts: assert property (
    trig_rd && any_single |=> o_trigger_busy)
    else $error("trigger read did not wait");
  a_trig_no_stall: assert property (
    trig_rd && g_en && !any_single && !o_trigger_busy |=> !o_trigger_busy)
    else $error("trigger read stalled with no single compare");
  a_busy_bounded: assert property (
    $rose(o_trigger_busy) |-> ##[1:20] !o_trigger_busy)
    else $error("trigger wait did not end");
endmodule

bind comparator_pair_control comparator_pair_checker #(.STARTUP(STARTUP))
  u_chk (.i_mclk, .i_rst, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata,
  .i_cmp_raw, .i_event_in, .i_sleep, .o_analog_enable, .o_event_out,
  .o_irq_cond, .o_trigger_busy, .o_clk_request);

`default_nettype wire

// >>> test/analog_cores_model.sv
// behavioural pair of analog comparator cores
// assumes the bench sets which input of each core is the higher
`timescale 1ns/100ps
`default_nettype none

module analog_cores_model (
  input  wire logic       i_mclk,
  input  wire logic [1:0] i_enable,
  input  wire logic [1:0] i_plus_gt,
  output logic      [1:0] o_raw
);
  logic [1:0] last = 2'h0;

  always @(posedge i_mclk) begin
    last <= o_raw;
  end
  // unpowered core shows no stale result: inverse of its last level
  assign o_raw = (i_enable & i_plus_gt) | (~i_enable & ~last);
endmodule

`default_nettype wire

// >>> test/test_comparator_pair_control.sv
// self-checking bench for the comparator pair control
// assumes the package, the cores model and the checker are compiled first
`timescale 1ns/100ps
`default_nettype none

module test_comparator_pair_control;
  import comparator_pair_pkg::*;
  localparam logic [31:0] ALL = 32'hffff_ffff;
  logic              i_mclk = 1'b0;
  logic              i_rst = 1'b1;
  logic [ADDR_W-1:0] i_addr = 8'h00;
  logic [31:0]       i_wdata = 32'h0;
  logic              i_wr = 1'b0;
  logic              i_rd = 1'b0;
  logic [31:0]       o_rdata;
  logic [1:0]        i_cmp_raw;
  logic [1:0]        i_event_in = 2'h0;
  logic              i_sleep = 1'b0;
  logic [1:0]        o_analog_enable, o_event_out, o_irq_cond;
  logic              o_trigger_busy, o_clk_request;
  logic [1:0]        lvl = 2'h0;
  logic [31:0]       exp_q[$], msk_q[$];
  logic              rd_d = 1'b0, en_d = 1'b0;
  int num_errors = 0, check_count = 0, cycles = 0, seed = 74795;
  int irq0 = 0, irq1 = 0, rise_n = 0, req_n = 0;

  comparator_pair_control #(.STARTUP(4)) dut (.i_mclk, .i_rst, .i_addr,
    .i_wdata, .i_wr, .i_rd, .o_rdata, .i_cmp_raw, .i_event_in, .i_sleep,
    .o_analog_enable, .o_event_out, .o_irq_cond, .o_trigger_busy,
    .o_clk_request);
  analog_cores_model cores (.i_mclk(i_mclk), .i_enable(o_analog_enable),
    .i_plus_gt(lvl), .o_raw(i_cmp_raw));

  always #5 i_mclk = ~i_mclk;

  task automatic give_verdict();
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] e,
                       input string what);
    check_count++;
    if (got !== e) begin
      num_errors++;
      $display("[ERR] %0t %s got %h exp %h", $time, what, got, e);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge i_mclk);
  endtask

  task automatic bus(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge i_mclk);
    i_wr    <= wr;
    i_rd    <= !wr;
    i_addr  <= a;
    i_wdata <= d;
    @(posedge i_mclk);
    i_wr <= 1'b0;
    i_rd <= 1'b0;
  endtask

  // the note is taken before the strobe, the monitor pops it later
  task automatic rd(input logic [7:0] a, input logic [31:0] e,
                    input logic [31:0] m);
    exp_q.push_back(e & m);
    msk_q.push_back(m);
    bus(1'b0, a, 32'h0);
  endtask

  task automatic pulse_event(input logic [1:0] e);
    i_event_in <= e;
    @(posedge i_mclk);
    i_event_in <= 2'h0;
  endtask

  task automatic wait_busy();
    for (int k = 0; k < 40 && o_trigger_busy !== 1'b0; k++) begin
      tick(1);
    end
    check(o_trigger_busy, 1'b0, "trigger wait");
  endtask

  task automatic done(input string name);
    $display("test %s finished", name);
  endtask

  always @(posedge i_mclk) begin
    rd_d <= i_rd;
    if (rd_d) begin
      check(o_rdata & msk_q.pop_front(), exp_q.pop_front(), "read");
    end
  end

  always @(posedge i_mclk) begin
    cycles++;
    irq0 += int'(o_irq_cond[0] === 1'b1);
    irq1 += int'(o_irq_cond[1] === 1'b1);
    req_n += int'(o_clk_request === 1'b1);
    rise_n += int'(o_analog_enable[0] === 1'b1 && !en_d);
    en_d = (o_analog_enable[0] === 1'b1);
    if (cycles == 20000) begin
      num_errors++;
      give_verdict();
    end
  end

  initial begin
    logic v;
    int   r, e, sel;
    tick(20);
    i_rst <= 1'b0;
    rd(OFS_GLOBAL_CONTROL, 32'h0, ALL);
    rd(OFS_EVENT_CONTROL, 32'h0, ALL);
    rd(OFS_COMP_CONTROL0, 32'h0, ALL);
    bus(1'b1, 8'h20, ALL);
    rd(8'h20, 32'h0, ALL);
    bus(1'b1, OFS_EVENT_CONTROL, 32'h33);
    bus(1'b1, OFS_GLOBAL_CONTROL, 32'h2);
    bus(1'b1, OFS_EVENT_CONTROL, 32'h0);
    rd(OFS_EVENT_CONTROL, 32'h33, ALL);
    bus(1'b1, OFS_COMP_CONTROL0, 32'hf);
    bus(1'b1, OFS_COMP_CONTROL0, 32'h1);
    rd(OFS_COMP_CONTROL0, 32'hf, ALL);
    done("config");
    for (int i = 0; i < 4; i++) begin
      v = 1'($random(seed));
      lvl[0] <= v;
      bus(1'b1, OFS_START_REGISTER, 32'h1);
      rd(OFS_READY_STATUS, 32'h0, 32'h1);
      tick(12);
      lvl[0] <= ~v;
      rd(OFS_STATE_STATUS, {31'h0, v}, 32'h1);
      rd(OFS_READY_STATUS, 32'h1, 32'h1);
      tick(12);
      rd(OFS_STATE_STATUS, {31'h0, v}, 32'h1);
    end
    done("single");
    for (int s = 0; s < 16; s++) begin
      sel = s >> 2;
      bus(1'b1, OFS_COMP_CONTROL0, 32'h0);
      bus(1'b1, OFS_COMP_CONTROL0, 32'(3 + 4 * sel));
      lvl[0] <= s[0];
      bus(1'b1, OFS_START_REGISTER, 32'h1);
      tick(12);
      r = irq0;
      lvl[0] <= s[1];
      bus(1'b1, OFS_START_REGISTER, 32'h1);
      tick(12);
      e = (sel == 3) ? 1 : (sel == 0) ? int'(s[0] ^ s[1]) :
          (sel == 1) ? int'(!s[0] && s[1]) : int'(s[0] && !s[1]);
      check(32'(irq0 - r), 32'(e), "irq count");
    end
    done("irq select");
    for (int j = 0; j < 2; j++) begin
      lvl[0] <= j[0];
      r = rise_n;
      if (j == 0) begin
        bus(1'b1, OFS_START_REGISTER, 32'h1);
      end
      rd(OFS_TRIGGER_STATUS, {31'h0, j[0]}, 32'h1);
      tick(1);
      check(o_trigger_busy, 1'b1, "trigger busy");
      wait_busy();
      check(32'(rise_n - r), 32'h1, "compares started");
      rd(OFS_STATE_STATUS, {31'h0, j[0]}, 32'h1);
    end
    done("trigger");
    for (int i = 0; i < 2; i++) begin
      lvl[0] <= ~i[0];
      pulse_event(2'h1);
      rd(OFS_READY_STATUS, 32'h0, 32'h1);
      tick(12);
      rd(OFS_STATE_STATUS, {31'h0, ~i[0]}, 32'h1);
      check(o_event_out[0], {31'h0, ~i[0]}, "event out");
    end
    done("event");
    lvl[1] <= 1'b1;
    bus(1'b1, OFS_COMP_CONTROL1, 32'h101);
    tick(15);
    rd(OFS_READY_STATUS, 32'h2, 32'h2);
    rd(OFS_STATE_STATUS, 32'h2, 32'h2);
    r = irq1;
    lvl[1] <= 1'b0;
    tick(1);
    lvl[1] <= 1'b1;
    tick(10);
    rd(OFS_STATE_STATUS, 32'h2, 32'h2);
    check(o_event_out[1], 1'b1, "event follows result");
    lvl[1] <= 1'b0;
    tick(10);
    rd(OFS_STATE_STATUS, 32'h0, 32'h2);
    check(32'(irq1 - r), 32'h1, "toggle count");
    done("continuous");
    bus(1'b1, OFS_GLOBAL_CONTROL, 32'h0);
    tick(3);
    check(o_analog_enable, 2'h0, "cores stopped");
    rd(OFS_COMP_CONTROL1, 32'h101, ALL);
    bus(1'b1, OFS_GLOBAL_CONTROL, 32'h2);
    tick(3);
    check(o_analog_enable[1], 1'b1, "core restarted");
    i_sleep <= 1'b1;
    tick(12);
    r = req_n;
    lvl[1] <= 1'b1;
    tick(12);
    check(32'(req_n > r), 32'h1, "clock for toggle");
    bus(1'b1, OFS_COMP_CONTROL1, 32'h100);
    tick(4);
    r = req_n;
    pulse_event(2'h1);
    tick(12);
    check(32'(req_n > r), 32'h1, "clock for event");
    check(o_clk_request, 1'b0, "clock released");
    bus(1'b1, OFS_GLOBAL_CONTROL, 32'h6);
    tick(2);
    check(o_clk_request, 1'b1, "clock kept to wake");
    i_sleep <= 1'b0;
    done("sleep");
    bus(1'b1, OFS_COMP_CONTROL0, 32'he);
    rd(OFS_TRIGGER_STATUS, 32'h0, ALL);
    tick(1);
    check(o_trigger_busy, 1'b0, "no stall");
    bus(1'b1, OFS_GLOBAL_CONTROL, 32'h3);
    rd(OFS_GLOBAL_CONTROL, 32'h0, ALL);
    rd(OFS_EVENT_CONTROL, 32'h0, ALL);
    rd(OFS_COMP_CONTROL0, 32'h0, ALL);
    check(o_analog_enable, 2'h0, "reset cores off");
    done("soft reset");
    tick(4);
    give_verdict();
  end
endmodule

`default_nettype wire
